// File: design/dep_pkg.sv
// constants for the dma enable / pause control block
// assumes one 20 MHz clock and a simple strobe register port
package dep_pkg;
  localparam int NUM_CH = 8;
  localparam logic [4:0] ADDR_GLOBAL = 5'h00;
  localparam logic [4:0] ADDR_CFGA_BASE = 5'h10;
  localparam logic [4:0] ADDR_CFGB_BASE = 5'h08;
  localparam int POS_GLOBAL_ENABLE = 31;
  localparam int POS_STOP_STATUS = 30;
  localparam int POS_PRIORITY_ROTATE = 28;
  localparam int POS_PAUSE_LO = 24;
  localparam int POS_CH_ENABLE = 31;
  localparam int POS_CH_PAUSE = 30;
  localparam int POS_SOFT_TRIGGER = 29;
  localparam int POS_REPEAT_ENABLE = 0;
  localparam int POS_MODE_LO = 28;
  localparam logic [1:0] MODE_BLOCK = 2'h0;
  localparam logic [1:0] MODE_BURST = 2'h1;
  localparam logic [1:0] MODE_DEMAND = 2'h2;
  localparam logic [31:0] GLOBAL_RESET = 32'h0000_0000;
  localparam logic [31:0] CFGA_RESET = 32'h0000_0000;
  localparam logic [31:0] CFGB_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_WAIT = 2'b01,
    CH_XFER = 2'b11,
    CH_PAUSE = 2'b10
  } dep_ch_state_t;
endpackage

// File: design/dep_control.sv
// global and per-channel enable, pause, stop status and priority for eight dma channels
// assumes request, grant-done inputs synchronous to clk_sys; register reads answer a cycle later
// How it works
// - global enable zero blocks all channels and stops active ones; resets zero
// - global enable one lets each channel run by its own settings
// - stop status sets once global enable is zero and no channel is transferring or paused
// - stop status sets once pause field nonzero and all transfers are paused
// - stop status clears when enabled and pause field is zero
// - software writes to stop status change nothing
// - rotate bit zero gives fixed priority, channel 0 highest
// - rotate bit one gives rotating priority among channels
// - nonzero pause field pauses transferring channels; zero resumes; resets zero
// - paused channel ignores transfer requests while paused
// - block or burst pause release resumes the transfer at once; the next grant waits for the request to drop
// - channel enable arms wait for trigger, only while globally enabled
// - completion clears channel enable unless repeat enable is set
// - channel enable zero keeps channel idle and stops an active transfer
// - channel pause bit pauses a transferring channel; clearing resumes
// - completion clears the channel pause bit
// - global stop ends transfers and resets state; global pause keeps configuration
// - channel stop resets its state; channel pause keeps its configuration
// - global disable leaves channel enable bits set
// - forced stop out of transfer raises an unsuccessful-completion pulse
`timescale 1ns/10ps
module dep_control
  import dep_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [4:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  input wire logic [dep_pkg::NUM_CH-1:0] xferReq,
  input wire logic [dep_pkg::NUM_CH-1:0] xferDone,
  output logic [dep_pkg::NUM_CH-1:0] grant,
  output logic [dep_pkg::NUM_CH-1:0] chActive,
  output logic [dep_pkg::NUM_CH-1:0] abortPulse,
  output logic [dep_pkg::NUM_CH-1:0] donePulse
);
  import dep_pkg::*;

  logic [31:0] globalReg;
  logic [31:0] cfgaReg [NUM_CH];
  logic [31:0] cfgbReg [NUM_CH];
  dep_ch_state_t chState [NUM_CH];
  logic [NUM_CH-1:0] xferring;
  logic [NUM_CH-1:0] pausedNow;
  logic [NUM_CH-1:0] eligible;
  logic [NUM_CH-1:0] grant_next;
  logic [2:0] lastGrant_reg;
  logic [NUM_CH-1:0] needNewReq_reg;
  logic [NUM_CH-1:0] abort_next;
  logic [NUM_CH-1:0] done_next;
  logic [31:0] rd_next;
  logic globalEnable;
  logic globalPaused;
  logic wrGlobal;
  logic [NUM_CH-1:0] wrCfga;
  logic [NUM_CH-1:0] wrCfgb;

  function automatic logic isChAddr(input logic [4:0] a, input logic [4:0] base,
                                    input int ch);
    return a == (base + 5'(ch));
  endfunction

  assign globalEnable = globalReg[POS_GLOBAL_ENABLE];
  assign globalPaused = |globalReg[POS_PAUSE_LO+3:POS_PAUSE_LO];
  assign wrGlobal = regWrStb && (regAddr == ADDR_GLOBAL);

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      wrCfga[i] = regWrStb && isChAddr(regAddr, ADDR_CFGA_BASE, i);
      wrCfgb[i] = regWrStb && isChAddr(regAddr, ADDR_CFGB_BASE, i);
      xferring[i] = (chState[i] == CH_XFER);
      pausedNow[i] = (chState[i] == CH_PAUSE);
    end
  end

  // global register; stop status is owned by hardware so cpu data for it is dropped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      globalReg <= GLOBAL_RESET;
    end else begin
      logic [31:0] g;
      logic stopFlag;
      g = wrGlobal ? regWrData : globalReg;
      stopFlag = globalReg[POS_STOP_STATUS];
      if (g[POS_GLOBAL_ENABLE] && (g[POS_PAUSE_LO+3:POS_PAUSE_LO] == 4'h0)) begin
        stopFlag = 1'b0;
      end else if (!globalEnable && (xferring == '0) && (pausedNow == '0)) begin
        stopFlag = 1'b1;
      end else if (globalPaused && (xferring == '0)) begin
        stopFlag = 1'b1;
      end
      g[POS_STOP_STATUS] = stopFlag;
      globalReg <= g;
    end
  end

  // channel config b holds repeat enable and mode; only written by software
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < NUM_CH; i++) cfgbReg[i] <= CFGB_RESET;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wrCfgb[i]) cfgbReg[i] <= regWrData;
      end
    end
  end

  // channel config a: software writes, hardware clears pause, trigger and, without repeat, enable on completion
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < NUM_CH; i++) cfgaReg[i] <= CFGA_RESET;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        logic [31:0] a;
        a = wrCfga[i] ? regWrData : cfgaReg[i];
        // completion wins over a simultaneous software write of these bits
        if (done_next[i]) begin
          if (!cfgbReg[i][POS_REPEAT_ENABLE]) a[POS_CH_ENABLE] = 1'b0;
          a[POS_CH_PAUSE] = 1'b0;
          a[POS_SOFT_TRIGGER] = 1'b0;
        end
        // global disable does not touch channel enable bits
        cfgaReg[i] <= a;
      end
    end
  end

  // arbitration: pick one eligible requester per cycle
  always_comb begin
    logic found;
    int idx;
    idx = 0;
    found = 1'b0;
    grant_next = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      // only a waiting channel competes; a running one must not be granted again
      eligible[i] = (chState[i] == CH_WAIT)
                    && (xferReq[i] || cfgaReg[i][POS_SOFT_TRIGGER])
                    && !needNewReq_reg[i];
    end
    for (int k = 0; k < NUM_CH; k++) begin
      if (globalReg[POS_PRIORITY_ROTATE]) begin
        idx = (int'(lastGrant_reg) + 1 + k) % NUM_CH;
      end else begin
        idx = k;
      end
      if (!found && eligible[idx]) begin
        grant_next[idx] = 1'b1;
        found = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lastGrant_reg <= 3'h0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (grant_next[i]) lastGrant_reg <= 3'(i);
      end
    end
  end

  // per-channel state machine
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      abort_next[i] = 1'b0;
      done_next[i] = 1'b0;
      if (xferring[i] || pausedNow[i]) begin
        if (!globalEnable || !cfgaReg[i][POS_CH_ENABLE]) begin
          abort_next[i] = xferring[i];
        end else if (xferring[i] && xferDone[i]) begin
          done_next[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < NUM_CH; i++) chState[i] <= CH_IDLE;
      needNewReq_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        logic en;
        logic hold;
        logic blockLike;
        en = globalEnable && cfgaReg[i][POS_CH_ENABLE];
        hold = globalPaused || cfgaReg[i][POS_CH_PAUSE];
        blockLike = (cfgbReg[i][POS_MODE_LO+1:POS_MODE_LO] == MODE_BLOCK)
                    || (cfgbReg[i][POS_MODE_LO+1:POS_MODE_LO] == MODE_BURST);
        if (!en) begin
          chState[i] <= CH_IDLE;
          needNewReq_reg[i] <= 1'b0;
        end else begin
          case (chState[i])
            CH_IDLE: chState[i] <= CH_WAIT;
            CH_WAIT: begin
              if (grant_next[i]) chState[i] <= CH_XFER;
            end
            CH_XFER: begin
              if (xferDone[i]) begin
                chState[i] <= cfgbReg[i][POS_REPEAT_ENABLE] ? CH_WAIT : CH_IDLE;
              end else if (hold) begin
                chState[i] <= CH_PAUSE;
              end
            end
            CH_PAUSE: begin
              if (!hold) begin
                chState[i] <= CH_XFER;
                needNewReq_reg[i] <= blockLike;
              end
            end
            default: chState[i] <= CH_IDLE;
          endcase
          if (needNewReq_reg[i] && !xferReq[i] && chState[i] == CH_XFER) begin
            needNewReq_reg[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      grant <= '0;
      abortPulse <= '0;
      donePulse <= '0;
      chActive <= '0;
    end else begin
      grant <= grant_next & ~(xferring & {NUM_CH{globalPaused}});
      abortPulse <= abort_next;
      donePulse <= done_next;
      chActive <= xferring;
    end
  end

  // read port
  always_comb begin
    rd_next = UNMAPPED_READ;
    if (regAddr == ADDR_GLOBAL) rd_next = globalReg;
    for (int i = 0; i < NUM_CH; i++) begin
      if (isChAddr(regAddr, ADDR_CFGA_BASE, i)) rd_next = cfgaReg[i];
      if (isChAddr(regAddr, ADDR_CFGB_BASE, i)) rd_next = cfgbReg[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regRdData <= UNMAPPED_READ;
    end else if (regRdStb) begin
      regRdData <= rd_next;
    end else begin
      regRdData <= UNMAPPED_READ;
    end
  end
endmodule // dep_control

// File: verification/dep_control_properties.sv
// port-level assertions for dep_control, bound to every instance
// assumes one clk_sys domain with synchronous active-high srst
`timescale 1ns/10ps
module dep_control_properties
  import dep_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [4:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic [NUM_CH-1:0] grant,
  input wire logic [NUM_CH-1:0] chActive,
  input wire logic [NUM_CH-1:0] abortPulse,
  input wire logic [NUM_CH-1:0] donePulse,
  input wire logic [NUM_CH-1:0] xferDone
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_grant_onehot: assert property ($onehot0(grant))
    else $error("grant not one-hot");
  a_grant_single: assert property (grant != 0 |=> (grant & $past(grant)) == 0)
    else $error("grant held twice");
  a_done_cause: assert property (donePulse != 0 |-> (donePulse & ~$past(xferDone)) == 0)
    else $error("done without completion");
  a_abort_cause: assert property (abortPulse != 0 |-> (abortPulse & ~chActive) == 0)
    else $error("abort without transfer");
  a_end_exclusive: assert property ((abortPulse & donePulse) == 0)
    else $error("abort and done together");
  a_read_idle: assert property (!$past(regRdStb) |-> regRdData == 32'h0000_0000)
    else $error("read data outside slot");
  a_reset_quiet: assert property ($past(srst) |-> (grant | chActive | abortPulse | donePulse) == 0)
    else $error("outputs busy after reset");
  a_disable_stops: assert property (regWrStb && regAddr == ADDR_GLOBAL &&
      !regWrData[POS_GLOBAL_ENABLE] |-> ##[1:3] chActive == 0)
    else $error("global disable left channel active");
  c_grant: cover property (grant != 0);
  c_done: cover property (donePulse != 0);
  c_abort: cover property (abortPulse != 0);
endmodule // dep_control_properties
bind dep_control dep_control_properties chk (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .grant(grant), .chActive(chActive), .abortPulse(abortPulse), .donePulse(donePulse),
  .xferDone(xferDone));

// File: verification/dep_xfer_partner.sv
// peripheral request sources plus a transfer engine that finishes granted channels
// assumes grants one-hot; lowest busy channel is served first, stall freezes the engine
`timescale 1ns/10ps
module dep_xfer_partner
  import dep_pkg::*;
#(parameter int XFER_LEN = 4)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [NUM_CH-1:0] grant,
  input wire logic [NUM_CH-1:0] reqSet,
  input wire logic stall,
  input wire logic flush,
  output logic [NUM_CH-1:0] xferReq,
  output logic [NUM_CH-1:0] xferDone
);
  logic [NUM_CH-1:0] busy_reg;
  logic [7:0] cnt_reg;
  logic [NUM_CH-1:0] lowBit;
  assign lowBit = busy_reg & (~busy_reg + 1'b1);
  always_ff @(posedge clk_sys) begin
    xferDone <= '0;
    if (srst || flush) begin
      xferReq <= '0;
      busy_reg <= '0;
      cnt_reg <= 8'(XFER_LEN);
    end else if (busy_reg != 0 && !stall && cnt_reg == 8'h01) begin
      // request drops once served, so a later start needs a fresh request
      xferDone <= lowBit;
      xferReq <= (xferReq | reqSet) & ~lowBit;
      busy_reg <= (busy_reg | grant) & ~lowBit;
      cnt_reg <= 8'(XFER_LEN);
    end else begin
      xferReq <= xferReq | reqSet;
      busy_reg <= busy_reg | grant;
      if (busy_reg != 0 && !stall) cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule // dep_xfer_partner

// File: verification/tb_top.sv
// register-level tests of dep_control with a partner transfer engine
// assumes 20 MHz clk_sys and read data one cycle after the read strobe
`timescale 1ns/10ps
module tb_top;
  import dep_pkg::*;
  logic clk_sys, srst, regWrStb, regRdStb, stall, flush;
  logic [4:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic [7:0] xferReq, xferDone, grant, chActive, abortPulse, donePulse, reqSet, got, abortSeen;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  dep_control uut (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .xferReq(xferReq),
    .xferDone(xferDone), .grant(grant), .chActive(chActive), .abortPulse(abortPulse),
    .donePulse(donePulse));
  dep_xfer_partner peer (.clk_sys(clk_sys), .srst(srst), .grant(grant), .reqSet(reqSet),
    .stall(stall), .flush(flush), .xferReq(xferReq), .xferDone(xferDone));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    abortSeen <= srst ? 8'h00 : (abortSeen | abortPulse);
    if (cyc == 4000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // an idle cycle after each strobe keeps back-to-back calls from re-driving it in one step
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdChk(input logic [4:0] a, input logic [31:0] exp, input string what);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1 check(what, regRdData, exp);
    @(posedge clk_sys);
  endtask
  task automatic request(input logic [7:0] m);
    reqSet <= m;
    @(posedge clk_sys);
    reqSet <= 8'h00;
  endtask
  task automatic waitGrant();
    repeat (40) begin
      @(posedge clk_sys);
      #1 got = grant;
      if (got != 0) break;
    end
  endtask
  initial begin
    srst = 1'b1;
    regAddr = '0;
    regWrData = '0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    reqSet = '0;
    stall = 1'b0;
    flush = 1'b0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    rdChk(ADDR_CFGA_BASE, CFGA_RESET, "cfga0 reset");
    wr(ADDR_GLOBAL, 32'h0000_A5A5);
    rdChk(ADDR_GLOBAL, 32'h4000_A5A5, "global reserved");
    wr(ADDR_GLOBAL, 32'hC000_0000);
    rdChk(ADDR_GLOBAL, 32'h8000_0000, "global running");
    rdChk(5'h1F, UNMAPPED_READ, "unmapped");
    for (int i = 0; i < 8; i++) wr(ADDR_CFGA_BASE + 5'(i), 32'h8000_0000);
    request(8'hFF);
    for (int i = 0; i < 8; i++) begin
      waitGrant();
      check("fixed grant", 32'(got), 32'(1 << i));
    end
    repeat (10) @(posedge clk_sys);
    rdChk(ADDR_CFGA_BASE, 32'h0000_0000, "cfga0 after done");
    wr(ADDR_CFGB_BASE + 5'h03, 32'h0000_0001);
    wr(ADDR_CFGA_BASE + 5'h03, 32'h8000_0000);
    request(8'h08);
    repeat (15) @(posedge clk_sys);
    rdChk(ADDR_CFGA_BASE + 5'h03, 32'h8000_0000, "cfga3 repeat kept");
    wr(ADDR_CFGB_BASE, 32'h2000_0000);
    wr(ADDR_CFGA_BASE, 32'h8000_0000);
    stall <= 1'b1;
    request(8'h01);
    waitGrant();
    check("grant ch0", 32'(got), 32'h0000_0001);
    wr(ADDR_GLOBAL, 32'h8100_0000);
    repeat (2) @(posedge clk_sys);
    rdChk(ADDR_GLOBAL, 32'hC100_0000, "global paused");
    rdChk(ADDR_CFGA_BASE, 32'h8000_0000, "cfga0 in pause");
    wr(ADDR_GLOBAL, 32'h8000_0000); // pause field cleared to resume; stop status bit written as zero
    repeat (3) @(posedge clk_sys);
    wr(ADDR_GLOBAL, 32'h0000_0000);
    repeat (4) @(posedge clk_sys);
    check("abort ch0", 32'(abortSeen), 32'h0000_0001);
    check("active", 32'(chActive), 32'h0000_0000);
    rdChk(ADDR_CFGA_BASE, 32'h8000_0000, "cfga0 after stop");
    rdChk(ADDR_GLOBAL, 32'h4000_0000, "global stopped");
    complete_run();
  end
endmodule // tb_top
